// file: inc/swq_pkg.sv
// Purpose: shared constants and types for the wake-event qualifier
// Assumes: one always-on clock, registers on a plain strobe port
// Notes:   offsets are word indices on the plain port
package swq_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;

  // register offsets
  localparam logic [3:0] OFF_PM_EN_STS  = 4'h0;
  localparam logic [3:0] OFF_GPE_EN     = 4'h1;
  localparam logic [3:0] OFF_GPE_STS    = 4'h2;
  localparam logic [3:0] OFF_PM_CONFIG2 = 4'h3;
  localparam logic [3:0] OFF_DS_CFG     = 4'h4;
  localparam logic [3:0] OFF_GPIO_EN0   = 4'h5;
  localparam logic [3:0] OFF_GPIO_EN1   = 4'h6;
  localparam logic [3:0] OFF_GPIO_EN2   = 4'h7;
  localparam logic [3:0] OFF_WAKE_STATE = 4'h8;

  // pm enable/status fields
  localparam int PM_RTC_EN_BIT   = 0;
  localparam int PM_WAKE_STS_BIT = 15;
  // gp event enable fields
  localparam int GE_PME_B0_BIT   = 0;
  localparam int GE_PME_BIT      = 1;
  localparam int GE_WADT_BIT     = 2;
  localparam int GE_USB_CON_BIT  = 3;
  localparam int GE_HN_WKEN_BIT  = 4;
  localparam int GE_ACP_WK_BIT   = 5;
  localparam int GE_PCIE_DIS_BIT = 6;
  localparam int GE_WOL_OVR_BIT  = 7;
  localparam int GE_LAN_GPIO_BIT = 8;
  localparam int GE_SMBA_NAT_BIT = 9;
  // gp event status fields
  localparam int GS_PME_B0_BIT   = 0;
  localparam int GS_SMB_WAK_BIT  = 1;
  localparam int GS_TIER2_BIT    = 2;
  localparam int GS_GPIO_T1_BIT  = 3;
  // deep sleep config fields
  localparam int DS_USB_MODE_BIT = 0;

  localparam int N_GPIO_T1   = 72;
  localparam int N_GPIO_T2   = 24;
  localparam int N_USB_PORTS = 16;
  localparam int N_SYNC      = 14;

  localparam logic [31:0] RST_ZERO = 32'h0000_0000;

  // sleep category the host sits in
  typedef enum logic [4:0] {
    SWQ_S0      = 5'h01,
    SWQ_SX      = 5'h02,
    SWQ_DEEP    = 5'h04,
    SWQ_SX_PL   = 5'h08,
    SWQ_SX_RST  = 5'h10
  } swq_cat_t;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } swq_bus_t;

endpackage

// file: rtl/swq_qualifier.sv
// Purpose: qualify wake sources against enables and sleep category
// Assumes: sources are async pins, synchronised here to sys_clk
// Notes:   sleep entry and deep sleep handshake live elsewhere
// Operation
// RULE1 - rtc alarm gated by enable, not reset-type
// RULE2 - power button always wakes everywhere
// RULE3 - gpio wakes from normal sleep only
// RULE4 - input_a native unless pin is gpio
// RULE5 - audio sets bus0 status, needs bus0 enable
// RULE6 - primary pme gated by bus0 enable
// RULE7 - secondary pme wakes after power loss only
// RULE8 - pcie wake pin unless disabled
// RULE9 - smbus alert needs native mode, no deep
// RULE10 - native mode persists until gpio, g3, deep
// RULE11 - smbus wake message always honored, no deep
// RULE12 - host notify gated, sets smbus wake status
// RULE13 - manageability wake always on, no deep
// RULE14 - wol override wakes from every category
// RULE15 - ac change wakes deep to sleep only
// RULE16 - usb deep enable only in/after deep
// RULE17 - usb needs port enable and route mode
// RULE18 - battery low blocks every wake
// RULE19 - 72 direct gpio bits, tier2 summary
// RULE20 - reset-type shutdown causes listed and merged
// RULE21 - events latched while battery low
// RULE22 - wake sets wake status, goes to s0
// RULE23 - sync, qualify, combine into one request
//
// The implementer's own choices: the plain strobed port and the address map.
`timescale 1ns/10ps
module swq_qualifier (
  // clock and reset
  input  wire logic                         sys_clk,
  input  wire logic                         resetn,
  // register port
  input  wire swq_pkg::swq_bus_t            bus,
  output logic [swq_pkg::DATA_W-1:0]        rdata,
  // sleep state from the sequencer
  input  wire logic                         in_sleep,
  input  wire logic                         in_deep_sleep,
  input  wire logic                         after_power_loss,
  input  wire logic                         after_deep_sleep,
  input  wire logic                         g3_event,
  input  wire logic                         deep_entry,
  // reset-type shutdown causes, latched on entry
  input  wire logic [6:0]                   rst_type_cause,
  // wake sources (async)
  input  wire logic                         rtc_alarm,
  input  wire logic                         power_button,
  input  wire logic [swq_pkg::N_GPIO_T1-1:0] gpio_t1,
  input  wire logic [swq_pkg::N_GPIO_T2-1:0] gpio_t2,
  input  wire logic                         input_a,
  input  wire logic                         audio_wake,
  input  wire logic                         pme_primary,
  input  wire logic                         pme_secondary,
  input  wire logic                         pcie_wake_n,
  input  wire logic                         smbus_alert_n,
  input  wire logic                         smbus_wake_msg,
  input  wire logic                         smbus_host_notify,
  input  wire logic                         mgmt_wake,
  input  wire logic                         wol_wake,
  input  wire logic                         wake_alarm_dev,
  input  wire logic                         ac_present_input,
  input  wire logic [swq_pkg::N_USB_PORTS-1:0] usb_connect,
  input  wire logic                         battery_low_input,
  // results
  output logic                              wake_request,
  output logic                              wake_to_sleep_only,
  output logic                              wake_status
);

  // synchroniser: three stages, change taken when 2nd and 3rd agree
  localparam int NS = swq_pkg::N_SYNC + swq_pkg::N_GPIO_T1
                      + swq_pkg::N_GPIO_T2 + swq_pkg::N_USB_PORTS;
  logic [NS-1:0] raw;
  logic [NS-1:0] s1_reg, s2_reg, s3_reg, clean_reg;

  assign raw = {usb_connect, gpio_t2, gpio_t1,
                rtc_alarm, power_button, input_a, audio_wake,
                pme_primary, pme_secondary, ~pcie_wake_n,
                ~smbus_alert_n, smbus_wake_msg, smbus_host_notify,
                mgmt_wake, wol_wake, wake_alarm_dev, battery_low_input};

  genvar gi;
  generate
    for (gi = 0; gi < NS; gi++) begin : g_sync
      always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          s1_reg[gi]    <= 1'b0;
          s2_reg[gi]    <= 1'b0;
          s3_reg[gi]    <= 1'b0;
          clean_reg[gi] <= 1'b0;
        end else begin
          s1_reg[gi] <= raw[gi];
          s2_reg[gi] <= s1_reg[gi];
          s3_reg[gi] <= s2_reg[gi];
          if (s2_reg[gi] == s3_reg[gi]) begin // RULE23
            clean_reg[gi] <= s3_reg[gi];
          end
        end
      end
    end
  endgenerate

  // ac present has its own chain: only its edges matter
  logic ac1_reg, ac2_reg, ac3_reg, ac_clean_reg, ac_prev_reg;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ac1_reg      <= 1'b0;
      ac2_reg      <= 1'b0;
      ac3_reg      <= 1'b0;
      ac_clean_reg <= 1'b0;
      ac_prev_reg  <= 1'b0;
    end else begin
      ac1_reg <= ac_present_input;
      ac2_reg <= ac1_reg;
      ac3_reg <= ac2_reg;
      if (ac2_reg == ac3_reg) begin
        ac_clean_reg <= ac3_reg;
      end
      ac_prev_reg <= ac_clean_reg;
    end
  end

  // named views of the clean sources
  logic bat_low, wadt, wol, mgmt, hnote, smsg, salert, pcie, pme2, pme1;
  logic audio, lan, pbtn, rtc;
  logic [swq_pkg::N_GPIO_T1-1:0]    g1;
  logic [swq_pkg::N_GPIO_T2-1:0]    g2;
  logic [swq_pkg::N_USB_PORTS-1:0]  usb;
  assign {usb, g2, g1, rtc, pbtn, lan, audio, pme1, pme2, pcie, salert,
          smsg, hnote, mgmt, wol, wadt, bat_low} = clean_reg;

  // registers
  logic [31:0] pm_enable_status_reg;
  logic [31:0] gp_event_enable_reg;
  logic [31:0] gp_event_status_reg;
  logic [31:0] pm_config2_reg;
  logic [31:0] deep_sleep_config_reg;
  logic [31:0] gpio_en_reg [3];

  function automatic logic hit(input swq_pkg::swq_bus_t b,
                               input logic [3:0] off);
    hit = b.wr && (b.addr == off);
  endfunction

  logic bus0_pme_enable, secondary_pme_enable, wake_alarm_enable;
  logic usb_connect_deep_wake_enable, host_notify_wake_enable;
  logic ac_present_wake_enable, pcie_wake_disable, wol_override;
  logic lan_is_gpio, usb_connect_route_mode;
  assign bus0_pme_enable   = gp_event_enable_reg[swq_pkg::GE_PME_B0_BIT];
  assign secondary_pme_enable = gp_event_enable_reg[swq_pkg::GE_PME_BIT];
  assign wake_alarm_enable = gp_event_enable_reg[swq_pkg::GE_WADT_BIT];
  assign usb_connect_deep_wake_enable =
         gp_event_enable_reg[swq_pkg::GE_USB_CON_BIT];
  assign host_notify_wake_enable =
         gp_event_enable_reg[swq_pkg::GE_HN_WKEN_BIT];
  assign ac_present_wake_enable = gp_event_enable_reg[swq_pkg::GE_ACP_WK_BIT];
  assign pcie_wake_disable = gp_event_enable_reg[swq_pkg::GE_PCIE_DIS_BIT];
  assign wol_override      = gp_event_enable_reg[swq_pkg::GE_WOL_OVR_BIT];
  assign lan_is_gpio       = gp_event_enable_reg[swq_pkg::GE_LAN_GPIO_BIT];
  assign usb_connect_route_mode =
         deep_sleep_config_reg[swq_pkg::DS_USB_MODE_BIT];

  // sleep category
  logic rst_type;
  swq_pkg::swq_cat_t cat;
  assign rst_type = |rst_type_cause; // RULE20
  always_comb begin
    if (in_deep_sleep) cat = swq_pkg::SWQ_DEEP;
    else if (!in_sleep) cat = swq_pkg::SWQ_S0;
    else if (rst_type) cat = swq_pkg::SWQ_SX_RST;
    else if (after_power_loss) cat = swq_pkg::SWQ_SX_PL;
    else cat = swq_pkg::SWQ_SX;
  end

  logic c_sx, c_deep, c_pl, c_rst;
  assign c_sx   = (cat == swq_pkg::SWQ_SX);
  assign c_deep = (cat == swq_pkg::SWQ_DEEP);
  assign c_pl   = (cat == swq_pkg::SWQ_SX_PL);
  assign c_rst  = (cat == swq_pkg::SWQ_SX_RST);

  // gpio wake enables, tier one mapped directly
  logic [95:0] gpio_en_all;
  assign gpio_en_all = {gpio_en_reg[2], gpio_en_reg[1], gpio_en_reg[0]};
  logic t1_hit, t2_hit;
  assign t1_hit = |(g1 & gpio_en_all[swq_pkg::N_GPIO_T1-1:0]); // RULE19
  assign t2_hit = |(g2 & gpio_en_all[95:swq_pkg::N_GPIO_T1]);  // RULE19

  // smbus alert native mode, sticky in resume well
  logic smba_native;
  assign smba_native = gp_event_enable_reg[swq_pkg::GE_SMBA_NAT_BIT];

  logic usb_hit;
  assign usb_hit = |(usb & pm_config2_reg[swq_pkg::N_USB_PORTS-1:0]);

  // per-source qualification
  logic q_main, q_ac, audio_blocked;
  assign audio_blocked = after_power_loss || rst_type_cause[0];
  always_comb begin
    q_main = 1'b0;
    if (rtc && pm_enable_status_reg[swq_pkg::PM_RTC_EN_BIT]
        && (c_sx || c_deep || c_pl)) q_main = 1'b1; // RULE1
    if (pbtn && (c_sx || c_deep || c_pl || c_rst)) q_main = 1'b1; // RULE2
    if ((t1_hit || t2_hit) && c_sx) q_main = 1'b1; // RULE3
    if (lan && !lan_is_gpio && (c_sx || c_deep || c_pl || c_rst))
      q_main = 1'b1; // RULE4
    if (audio && bus0_pme_enable && (c_sx || c_pl) && !audio_blocked)
      q_main = 1'b1; // RULE5
    if (pme1 && bus0_pme_enable && (c_sx || c_pl)) q_main = 1'b1; // RULE6
    if ((|usb) && bus0_pme_enable && c_sx && !after_deep_sleep)
      q_main = 1'b1; // RULE16
    if (pme2 && secondary_pme_enable && c_pl) q_main = 1'b1; // RULE7
    if (pcie && !pcie_wake_disable && (c_sx || c_deep || c_pl))
      q_main = 1'b1; // RULE8
    if (salert && smba_native && (c_sx || c_pl || c_rst))
      q_main = 1'b1; // RULE9
    if (smsg && (c_sx || c_pl || c_rst)) q_main = 1'b1; // RULE11
    if (hnote && host_notify_wake_enable && (c_sx || c_pl || c_rst))
      q_main = 1'b1; // RULE12
    if (mgmt && (c_sx || c_pl || c_rst)) q_main = 1'b1; // RULE13
    if (wol && wol_override && (c_sx || c_deep || c_pl || c_rst))
      q_main = 1'b1; // RULE14
    if (wadt && wake_alarm_enable && (c_sx || c_deep)) q_main = 1'b1;
    if (usb_hit && usb_connect_deep_wake_enable && usb_connect_route_mode
        && (c_deep || (c_sx && after_deep_sleep))) q_main = 1'b1; // RULE17
    q_ac = ac_present_wake_enable && (ac_clean_reg != ac_prev_reg)
           && c_deep; // RULE15
  end

  // usb connect in plain sleep takes the bus0 path instead
  logic usb_pme;
  assign usb_pme = (|usb) && c_sx && !after_deep_sleep; // RULE16

  // register writes
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pm_enable_status_reg  <= swq_pkg::RST_ZERO;
      pm_config2_reg        <= swq_pkg::RST_ZERO;
      deep_sleep_config_reg <= swq_pkg::RST_ZERO;
      gpio_en_reg[0]        <= swq_pkg::RST_ZERO;
      gpio_en_reg[1]        <= swq_pkg::RST_ZERO;
      gpio_en_reg[2]        <= swq_pkg::RST_ZERO;
    end else begin
      if (hit(bus, swq_pkg::OFF_PM_EN_STS))
        pm_enable_status_reg[swq_pkg::PM_RTC_EN_BIT] <=
          bus.wdata[swq_pkg::PM_RTC_EN_BIT];
      if (hit(bus, swq_pkg::OFF_PM_CONFIG2)) pm_config2_reg <= bus.wdata;
      if (hit(bus, swq_pkg::OFF_DS_CFG)) deep_sleep_config_reg <= bus.wdata;
      if (hit(bus, swq_pkg::OFF_GPIO_EN0)) gpio_en_reg[0] <= bus.wdata;
      if (hit(bus, swq_pkg::OFF_GPIO_EN1)) gpio_en_reg[1] <= bus.wdata;
      if (hit(bus, swq_pkg::OFF_GPIO_EN2)) gpio_en_reg[2] <= bus.wdata;
    end
  end

  // enable register; native smbus alert cleared by g3 or deep entry
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      gp_event_enable_reg <= swq_pkg::RST_ZERO;
    end else begin
      if (hit(bus, swq_pkg::OFF_GPE_EN)) gp_event_enable_reg <= bus.wdata;
      if (g3_event || deep_entry)
        gp_event_enable_reg[swq_pkg::GE_SMBA_NAT_BIT] <= 1'b0; // RULE10
    end
  end

  // status: write one to clear, a new event wins over the clear
  logic [31:0] gs_set;
  always_comb begin
    gs_set = swq_pkg::RST_ZERO;
    gs_set[swq_pkg::GS_PME_B0_BIT]  = audio || pme1 || usb_pme; // RULE5
    gs_set[swq_pkg::GS_SMB_WAK_BIT] =
      hnote && host_notify_wake_enable; // RULE12
    gs_set[swq_pkg::GS_TIER2_BIT]   = t2_hit; // RULE19
    gs_set[swq_pkg::GS_GPIO_T1_BIT] = t1_hit;
  end
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      gp_event_status_reg <= swq_pkg::RST_ZERO;
    end else if (hit(bus, swq_pkg::OFF_GPE_STS)) begin
      gp_event_status_reg <= (gp_event_status_reg & ~bus.wdata) | gs_set;
    end else begin
      gp_event_status_reg <= gp_event_status_reg | gs_set;
    end
  end

  // pending wake held through battery low
  logic pend_reg, pend_ac_reg;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pend_reg    <= 1'b0;
      pend_ac_reg <= 1'b0;
    end else if (!in_sleep && !in_deep_sleep) begin
      pend_reg    <= 1'b0;
      pend_ac_reg <= 1'b0;
    end else begin
      if (q_main) pend_reg <= 1'b1; // RULE21
      if (q_ac) pend_ac_reg <= 1'b1; // RULE21
    end
  end

  // request outputs, blocked while battery low
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wake_request       <= 1'b0;
      wake_to_sleep_only <= 1'b0;
    end else begin
      wake_request       <= (pend_reg || q_main) && !bat_low; // RULE18
      wake_to_sleep_only <= (pend_ac_reg || q_ac) && !pend_reg
                            && !q_main && !bat_low; // RULE15
    end
  end

  // wake status: set on full wake, write one to clear, set wins
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wake_status <= 1'b0;
    end else if (wake_request) begin
      wake_status <= 1'b1; // RULE22
    end else if (hit(bus, swq_pkg::OFF_PM_EN_STS)
                 && bus.wdata[swq_pkg::PM_WAKE_STS_BIT]) begin
      wake_status <= 1'b0;
    end
  end

  // read data, one cycle after the strobe, zero when unmapped
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rdata <= swq_pkg::RST_ZERO;
    end else if (!bus.rd) begin
      rdata <= swq_pkg::RST_ZERO;
    end else if (bus.addr == swq_pkg::OFF_PM_EN_STS) begin
      rdata <= pm_enable_status_reg
               | (32'(wake_status) << swq_pkg::PM_WAKE_STS_BIT);
    end else if (bus.addr == swq_pkg::OFF_GPE_EN) begin
      rdata <= gp_event_enable_reg;
    end else if (bus.addr == swq_pkg::OFF_GPE_STS) begin
      rdata <= gp_event_status_reg;
    end else if (bus.addr == swq_pkg::OFF_PM_CONFIG2) begin
      rdata <= pm_config2_reg;
    end else if (bus.addr == swq_pkg::OFF_DS_CFG) begin
      rdata <= deep_sleep_config_reg;
    end else if (bus.addr == swq_pkg::OFF_GPIO_EN0) begin
      rdata <= gpio_en_reg[0];
    end else if (bus.addr == swq_pkg::OFF_GPIO_EN1) begin
      rdata <= gpio_en_reg[1];
    end else if (bus.addr == swq_pkg::OFF_GPIO_EN2) begin
      rdata <= gpio_en_reg[2];
    end else if (bus.addr == swq_pkg::OFF_WAKE_STATE) begin
      rdata <= {24'h000000, pend_ac_reg, pend_reg, bat_low, 5'(cat)};
    end else begin
      rdata <= swq_pkg::RST_ZERO;
    end
  end

endmodule

// file: bench/swq_qualifier_checker.sv
// Purpose: port-level checks of the wake qualifier
// Assumes: one clock domain, resetn async active low
// Notes:   source pins are async, so windows allow for sync delay
`timescale 1ns/10ps
module swq_qualifier_checker (
  // clock and reset
  input wire logic              sys_clk,
  input wire logic              resetn,
  // inputs watched
  input wire swq_pkg::swq_bus_t bus,
  input wire logic              in_sleep,
  input wire logic              in_deep_sleep,
  input wire logic              power_button,
  input wire logic              battery_low_input,
  // outputs watched
  input wire logic              wake_request,
  input wire logic              wake_to_sleep_only,
  input wire logic              wake_status
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  logic clr_ws;
  assign clr_ws = bus.wr && bus.addr == swq_pkg::OFF_PM_EN_STS &&
                  bus.wdata[swq_pkg::PM_WAKE_STS_BIT];

  property p_bat_low_block;
    battery_low_input [*8] |-> !wake_request;
  endproperty
  a_bat_low_block: assert property (p_bat_low_block)
    else $error("wake request while battery low");
  property p_button_wakes;
    (power_button && in_sleep && !battery_low_input) [*8] |-> wake_request;
  endproperty
  a_button_wakes: assert property (p_button_wakes)
    else $error("power button did not wake");
  property p_pend_holds;
    !battery_low_input [*4] ##0 wake_request ##1
    (in_sleep && !battery_low_input) [*4] |-> wake_request;
  endproperty
  a_pend_holds: assert property (p_pend_holds)
    else $error("pending wake dropped in sleep");
  property p_s0_quiet;
    (!in_sleep && !in_deep_sleep) [*4] |-> !wake_request;
  endproperty
  a_s0_quiet: assert property (p_s0_quiet)
    else $error("wake request while fully on");
  property p_status_set;
    $rose(wake_request) |-> ##[1:2] wake_status;
  endproperty
  a_status_set: assert property (p_status_set)
    else $error("wake status not set after wake");
  property p_status_sticky;
    wake_status && !clr_ws |=> wake_status;
  endproperty
  a_status_sticky: assert property (p_status_sticky)
    else $error("wake status lost without clear");
  property p_status_cause;
    $rose(wake_status) |-> $past(wake_request) || $past(wake_request, 2);
  endproperty
  a_status_cause: assert property (p_status_cause)
    else $error("wake status set with no wake");
  property p_ac_deep_only;
    $rose(wake_to_sleep_only) |-> $past(in_deep_sleep);
  endproperty
  a_ac_deep_only: assert property (p_ac_deep_only)
    else $error("partial wake outside deep sleep");

  c_wake: cover property ($rose(wake_request));
  c_partial: cover property ($rose(wake_to_sleep_only));
  c_clear: cover property ($fell(wake_status));
endmodule

bind swq_qualifier swq_qualifier_checker i_swq_qualifier_checker (
  .sys_clk(sys_clk), .resetn(resetn), .bus(bus), .in_sleep(in_sleep),
  .in_deep_sleep(in_deep_sleep), .power_button(power_button),
  .battery_low_input(battery_low_input), .wake_request(wake_request),
  .wake_to_sleep_only(wake_to_sleep_only), .wake_status(wake_status));

// file: bench/swq_wake_sources.sv
// Purpose: platform wake sources and host sleep state
// Assumes: levels change just after a rising edge
// Notes:   index 0-16 sources, 17 battery low
`timescale 1ns/10ps
module swq_wake_sources (
  // clock
  input  wire logic   sys_clk,
  // single-bit pins, pin polarity
  output logic [17:0] pins,
  // vector sources
  output logic [71:0] gpio_t1,
  output logic [23:0] gpio_t2,
  output logic [15:0] usb_connect,
  // host sleep state
  output logic        in_sleep,
  output logic        in_deep_sleep,
  output logic        after_power_loss,
  output logic        after_deep_sleep,
  output logic        g3_event,
  output logic        deep_entry,
  output logic [6:0]  rst_type_cause
);
  logic [17:0] lvl = 18'h00000;

  // active-low wake pin and alert idle high; alert pin is gpio by default
  assign pins = lvl ^ 18'h00180;
  assign gpio_t1 = {71'h0, lvl[2]};
  assign gpio_t2 = {23'h0, lvl[16]};
  assign usb_connect = {15'h0000, lvl[15]};

  initial begin
    {in_sleep, in_deep_sleep, after_power_loss, after_deep_sleep} = 4'h0;
    {g3_event, deep_entry} = 2'b00;
    rst_type_cause = 7'h00;
  end

  task automatic set_src(input int s, input logic v);
    @(posedge sys_clk);
    lvl[s] <= v;
  endtask

  // 0 sleep, 1 deep, 2 power loss, 3 reset type, 4 after deep, 5 on
  task automatic set_cat(input int c, input logic [6:0] rc);
    @(posedge sys_clk);
    in_sleep <= c == 0 || (c >= 2 && c <= 4);
    in_deep_sleep <= c == 1;
    after_power_loss <= c == 2;
    after_deep_sleep <= c == 4;
    rst_type_cause <= (c == 3) ? rc : 7'h00;
  endtask

  task automatic pulse(input int k);
    @(posedge sys_clk);
    {g3_event, deep_entry} <= (k != 0) ? 2'b10 : 2'b01;
    @(posedge sys_clk);
    {g3_event, deep_entry} <= 2'b00;
  endtask
endmodule

// file: bench/swq_qualifier_tb_top.sv
// Purpose: self-checking bench for the wake qualifier
// Assumes: source model drives pins, bench drives the register port
// Notes:   each source is tried in every sleep category
`timescale 1ns/10ps
module swq_qualifier_tb_top;
  logic              sys_clk = 1'b0;
  logic              resetn = 1'b0;
  swq_pkg::swq_bus_t bus = '0;
  logic [31:0]       rdata;
  logic [17:0]       pins;
  logic [71:0]       gpio_t1;
  logic [23:0]       gpio_t2;
  logic [15:0]       usb;
  logic [6:0]        rcause;
  logic              slp, deep, apl, ads, g3, dent;
  logic              wake_request, wake_to_sleep_only, wake_status;
  int                compares = 0;
  int                miscompares = 0;
  // allowed categories per source: {after deep, reset, loss, deep, sleep}
  logic [4:0] tab [0:16] = '{5'h17, 5'h1F, 5'h11, 5'h1F, 5'h11, 5'h15,
    5'h04, 5'h17, 5'h1D, 5'h1D, 5'h1D, 5'h1D, 5'h1F, 5'h13, 5'h00,
    5'h13, 5'h11};
  logic [16:0] always_on = 17'h00A02;

  always #2 sys_clk = ~sys_clk;

  swq_qualifier i_swq_qualifier (
    .sys_clk(sys_clk), .resetn(resetn), .bus(bus), .rdata(rdata),
    .in_sleep(slp), .in_deep_sleep(deep), .after_power_loss(apl),
    .after_deep_sleep(ads), .g3_event(g3), .deep_entry(dent),
    .rst_type_cause(rcause), .rtc_alarm(pins[0]),
    .power_button(pins[1]), .gpio_t1(gpio_t1), .gpio_t2(gpio_t2),
    .input_a(pins[3]), .audio_wake(pins[4]), .pme_primary(pins[5]),
    .pme_secondary(pins[6]), .pcie_wake_n(pins[7]),
    .smbus_alert_n(pins[8]), .smbus_wake_msg(pins[9]),
    .smbus_host_notify(pins[10]), .mgmt_wake(pins[11]),
    .wol_wake(pins[12]), .wake_alarm_dev(pins[13]),
    .ac_present_input(pins[14]), .usb_connect(usb),
    .battery_low_input(pins[17]), .wake_request(wake_request),
    .wake_to_sleep_only(wake_to_sleep_only), .wake_status(wake_status));

  swq_wake_sources i_swq_wake_sources (
    .sys_clk(sys_clk), .pins(pins), .gpio_t1(gpio_t1), .gpio_t2(gpio_t2),
    .usb_connect(usb), .in_sleep(slp), .in_deep_sleep(deep),
    .after_power_loss(apl), .after_deep_sleep(ads), .g3_event(g3),
    .deep_entry(dent), .rst_type_cause(rcause));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge sys_clk);
    bus <= '0;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] m,
                        input logic [31:0] e);
    @(posedge sys_clk);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
    @(posedge sys_clk);
    bus <= '0;
    #1;
    check(rdata & m, e);
  endtask

  // p = 0 sets the rtc and event enables and only bit 0 of the gpio, tier2 and usb enables, p = 1 clears them except the usb port enable and route mode
  task automatic setup(input int p);
    wr_reg(swq_pkg::OFF_PM_EN_STS, (p != 0) ? 32'h0000_0000 : 32'h0000_0001);
    wr_reg(swq_pkg::OFF_GPE_EN, (p != 0) ? 32'h0000_0140 : 32'h0000_02BF);
    wr_reg(swq_pkg::OFF_GPIO_EN0, (p != 0) ? 32'h0000_0000 : 32'h0000_0001);
    wr_reg(swq_pkg::OFF_GPIO_EN2, (p != 0) ? 32'h0000_0000 : 32'h0000_0100);
    wr_reg(swq_pkg::OFF_PM_CONFIG2, 32'h0000_0001);
    wr_reg(swq_pkg::OFF_DS_CFG, 32'h0000_0001);
  endtask

  // the source stays up long enough to clear the synchroniser
  task automatic try_src(input int s, input int c, input logic e,
                         input logic ea);
    i_swq_wake_sources.set_cat(c, 7'h01 << (s % 7));
    i_swq_wake_sources.set_src(s, 1'b1);
    repeat (10) @(posedge sys_clk);
    #1;
    check(wake_request, e);
    check(wake_to_sleep_only, ea);
    i_swq_wake_sources.set_src(s, 1'b0);
    i_swq_wake_sources.set_cat(5, 7'h00);
    repeat (4) @(posedge sys_clk);
  endtask

  task automatic print_verdict();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    int n;
    repeat (5) @(posedge sys_clk);
    resetn <= 1'b1;
    rd_chk(swq_pkg::OFF_GPE_EN, 32'hFFFF_FFFF, swq_pkg::RST_ZERO);
    wr_reg(4'hF, 32'hFFFF_FFFF);
    rd_chk(4'hF, 32'hFFFF_FFFF, 32'h0000_0000);
    for (int p = 0; p < 2; p++) begin
      setup(p);
      for (int s = 0; s < 17; s++) begin
        for (int c = 0; c < 5; c++) begin
          try_src(s, c, tab[s][c] & (p == 0 || always_on[s]),
                  s == 14 && c == 1 && p == 0);
        end
      end
      if (p == 0) begin
        rd_chk(swq_pkg::OFF_GPE_STS, 32'h0000_000F, 32'h0000_000F);
        wr_reg(swq_pkg::OFF_GPE_STS, 32'h0000_000F);
        rd_chk(swq_pkg::OFF_GPE_STS, 32'h0000_000F, 32'h0000_0000);
        rd_chk(swq_pkg::OFF_PM_EN_STS, 32'h0000_8000, 32'h0000_8000);
        wr_reg(swq_pkg::OFF_PM_EN_STS, 32'h0000_8001);
        #1;
        check(wake_status, 1'b0);
      end
    end
    // native alert mode is dropped by deep entry and by g3
    for (int k = 0; k < 2; k++) begin
      setup(0);
      i_swq_wake_sources.pulse(k);
      try_src(8, 0, 1'b0, 1'b0);
    end
    wr_reg(swq_pkg::OFF_PM_CONFIG2, 32'h0000_0000);
    try_src(15, 1, 1'b0, 1'b0);
    wr_reg(swq_pkg::OFF_PM_CONFIG2, 32'h0000_0001);
    wr_reg(swq_pkg::OFF_DS_CFG, 32'h0000_0000);
    try_src(15, 1, 1'b0, 1'b0);
    // button pressed and released while the battery is low
    i_swq_wake_sources.set_src(17, 1'b1);
    i_swq_wake_sources.set_cat(0, 7'h00);
    i_swq_wake_sources.set_src(1, 1'b1);
    repeat (12) @(posedge sys_clk);
    #1;
    check(wake_request, 1'b0);
    // pending latched, battery low seen, plain sleep category
    rd_chk(swq_pkg::OFF_WAKE_STATE, 32'h0000_00FF, 32'h0000_0062);
    i_swq_wake_sources.set_src(1, 1'b0);
    repeat (6) @(posedge sys_clk);
    i_swq_wake_sources.set_src(17, 1'b0);
    n = 0;
    while (wake_request !== 1'b1 && n < 12) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    check(wake_request, 1'b1);
    i_swq_wake_sources.set_cat(5, 7'h00);
    repeat (4) @(posedge sys_clk);
    print_verdict();
  end
endmodule
